// [rtl/crt_char_interpreter.sv]
`timescale 1ns/10ps
module crt_char_interpreter import crt_char_pkg::*; #(
	parameter int COLS = COLS_DEF,
	parameter int LINES = LINES_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic inValid,
	input wire req_s inReq,
	input wire logic modeKey,
	input wire logic modeWrite,
	input wire logic [7:0] modeData,
	output logic wrValid,
	output wr_s wrOut,
	output logic scrollUp,
	output logic [1:0] blankLines,
	output logic beep,
	output logic ctrlDisplay,
	output attr_s attrState,
	output logic [6:0] printCol,
	output logic [6:0] printLine
);
	// position counters are 7 bits and must hold one past the last column or line
	if (COLS < 2 || COLS > 126 || LINES < 2 || LINES > 126) begin : g_badSize
		$error("crt_char_interpreter: COLS/LINES out of range");
	end
	localparam logic [6:0] COL_MAX = 7'(COLS);
	localparam logic [6:0] LINE_MAX = 7'(LINES);

	// ***************
	// mode key
	// ***************
	logic keyPress;
	key_sync u_key (
		.clk(clk),
		.rstn(rstn),
		.keyPin(modeKey),
		.keyPress(keyPress)
	);

	// ***************
	// next state
	// ***************
	logic mode_r, mode_nxt;
	attr_s attr_r, attr_nxt;
	logic [6:0] col_r, col_nxt, line_r, line_nxt;
	logic wrValid_r, wrValid_nxt, scroll_r, scroll_nxt, beep_r, beep_nxt;
	logic [1:0] blank_r, blank_nxt;
	wr_s wr_r, wr_nxt;
	logic [7:0] c;
	logic [6:0] wcol, wline;
	logic show;
	always_comb begin
		mode_nxt = mode_r;
		attr_nxt = attr_r;
		col_nxt = col_r;
		line_nxt = line_r;
		wrValid_nxt = 1'b0;
		scroll_nxt = 1'b0;
		beep_nxt = 1'b0;
		blank_nxt = 2'h0;
		wr_nxt = wr_r;
		c = inReq.code;
		show = 1'b0;
		wcol = col_r;
		wline = line_r;
		if (keyPress) begin
			mode_nxt = ~mode_r;
		end
		if (modeWrite && modeData != 8'h00) begin
			mode_nxt = 1'b1;
		end
		if (inValid) begin
			if (c[7:3] == ATTR_PATTERN) begin
				attr_nxt.underline = c[ATTR_UL_BIT];
				attr_nxt.blink = c[ATTR_BL_BIT];
				attr_nxt.inverse = c[ATTR_INV_BIT];
			end else if (c < CTRL_LIMIT) begin
				if (mode_r) begin
					show = 1'b1;
				end else begin
					case (c)
						CODE_BELL: beep_nxt = 1'b1;
						CODE_BS: if (col_r > POS_RESET) col_nxt = col_r - 7'h01;
						CODE_LF: line_nxt = line_r + 7'h01;
						CODE_FF: begin
							scroll_nxt = 1'b1;
							blank_nxt = 2'h2;
							col_nxt = POS_RESET;
							line_nxt = LINE_MAX;
						end
						CODE_CR: col_nxt = POS_RESET;
						default: ;
					endcase
				end
			end else if (c < PRINT_LIMIT) begin
				show = 1'b1;
			end
			if (show) begin
				if (col_r > COL_MAX) begin
					wcol = POS_RESET;
					wline = line_r + 7'h01;
				end
				if (!inReq.msgLine && wline > LINE_MAX) begin
					scroll_nxt = 1'b1;
					wline = LINE_MAX;
				end
				wrValid_nxt = 1'b1;
				wr_nxt.glyph = c;
				wr_nxt.attr = attr_r;
				wr_nxt.col = wcol;
				wr_nxt.line = wline;
				wr_nxt.msgLine = inReq.msgLine;
				if (inReq.msgLine) begin
					wr_nxt.line = line_r;
				end else if (mode_r && c == CODE_CR) begin
					col_nxt = POS_RESET;
					line_nxt = wline + 7'h01;
				end else begin
					col_nxt = wcol + 7'h01;
					line_nxt = wline;
				end
			end
		end
	end

	// ***************
	// registers
	// ***************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= 1'b0;
			attr_r <= ATTR_RESET;
			col_r <= POS_RESET;
			line_r <= POS_RESET;
			wrValid_r <= 1'b0;
			scroll_r <= 1'b0;
			beep_r <= 1'b0;
			blank_r <= 2'h0;
			wr_r <= '0;
		end else begin
			mode_r <= mode_nxt;
			attr_r <= attr_nxt;
			col_r <= col_nxt;
			line_r <= line_nxt;
			wrValid_r <= wrValid_nxt;
			scroll_r <= scroll_nxt;
			beep_r <= beep_nxt;
			blank_r <= blank_nxt;
			wr_r <= wr_nxt;
		end
	end
	assign wrValid = wrValid_r;
	assign wrOut = wr_r;
	assign scrollUp = scroll_r;
	assign blankLines = blank_r;
	assign beep = beep_r;
	assign ctrlDisplay = mode_r;
	assign attrState = attr_r;
	assign printCol = col_r;
	assign printLine = line_r;

	// ***************
	// checks
	// ***************
	sequence s_bell;
		inValid && inReq.code == CODE_BELL && !mode_r;
	endsequence
	AST_BELL: assert property (@(posedge clk) disable iff (!rstn) s_bell |=> beep && $stable(printCol) && !wrValid)
		else $error("bell did not beep cleanly");
	AST_BS: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code == CODE_BS && !mode_r |=> printCol == ($past(printCol) > 7'h01 ? $past(printCol) - 7'h01 : 7'h01))
		else $error("backspace column wrong");
	AST_LF: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code == CODE_LF && !mode_r |=> printLine == $past(printLine) + 7'h01 && $stable(printCol))
		else $error("line feed wrong");
	AST_FF: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code == CODE_FF && !mode_r |=> scrollUp && blankLines == 2'h2 && printCol == 7'h01)
		else $error("form feed wrong");
	AST_CR: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code == CODE_CR && !mode_r |=> printCol == 7'h01 && $stable(printLine))
		else $error("return wrong");
	AST_IGN: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code == 8'h01 && !mode_r && !keyPress && !modeWrite |=> !wrValid && $stable(printCol))
		else $error("ignored control acted");
	AST_ATTR: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code[7:3] == 5'h10 |=> attrState == $past(inReq.code[2:0]) && !wrValid)
		else $error("attribute not taken");
	AST_SHOW: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code < 8'h20 && mode_r |=> wrValid && wrOut.glyph == $past(inReq.code))
		else $error("control not shown");
	AST_WMODE: assert property (@(posedge clk) disable iff (!rstn)
		modeWrite && modeData != 8'h00 |=> ctrlDisplay)
		else $error("mode write ignored");
	sequence s_print;
		inValid && inReq.code >= CTRL_LIMIT && inReq.code < PRINT_LIMIT;
	endsequence
	// wrap is decided on arrival, so a full line costs no extra cycle
	AST_WRAP: assert property (@(posedge clk) disable iff (!rstn)
		s_print ##0 (!inReq.msgLine && printCol > COL_MAX) |=> wrValid && wrOut.col == 7'h01 && printCol == 7'h02)
		else $error("line wrap wrong");
	AST_SCROLL: assert property (@(posedge clk) disable iff (!rstn)
		s_print ##0 (!inReq.msgLine && printLine >= LINE_MAX && printCol > COL_MAX)
		|=> scrollUp && wrOut.line == LINE_MAX && printLine == LINE_MAX)
		else $error("off-screen glyph not scrolled");
	AST_VISIBLE: assert property (@(posedge clk) disable iff (!rstn)
		wrValid && !wrOut.msgLine |-> wrOut.line <= LINE_MAX)
		else $error("glyph written below screen");
	AST_MSG: assert property (@(posedge clk) disable iff (!rstn)
		s_print ##0 inReq.msgLine |=> wrValid && wrOut.msgLine && $stable(printCol) && $stable(printLine))
		else $error("message glyph moved position");
	AST_CRSHOW: assert property (@(posedge clk) disable iff (!rstn)
		inValid && inReq.code == CODE_CR && mode_r && !inReq.msgLine
		|=> wrValid && wrOut.glyph == CODE_CR && printCol == 7'h01 && printLine == wrOut.line + 7'h01)
		else $error("shown return did not advance line");
	AST_KEY: assert property (@(posedge clk) disable iff (!rstn)
		keyPress && !modeWrite |=> ctrlDisplay != $past(ctrlDisplay))
		else $error("key press did not toggle mode");
	AST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		!(inValid && inReq.code[7:3] == ATTR_PATTERN) |=> $stable(attrState))
		else $error("attributes changed without command");
	AST_BEEPSRC: assert property (@(posedge clk) disable iff (!rstn)
		beep |-> $past(inValid) && $past(inReq.code) == CODE_BELL && !$past(mode_r))
		else $error("beep without bell");
endmodule

// [rtl/crt_char_pkg.sv]
// Function
// - codes 0-31 act only if defined
// - code 7 pulses beeper, nothing else
// - code 8 backs column unless at 1
// - code 10 moves line down one
// - code 12 scrolls, two blanks, column 1
// - code 13 sets column 1, same line
// - codes 128-135 are attribute commands
// - attribute bits: underline, blink, inverse
// - attributes held until next code 128-135
// - same attributes for output and message line
// - display mode shows controls, no action except code 13
// - display mode return shows glyph, CR+LF
// - mode key press toggles display mode
// - nonzero control write sets display mode
// - output-line glyph advances column, wraps to next line
// - off-screen position scrolls before writing
// - visible output area is 18 lines
package crt_char_pkg;
	localparam int COLS_DEF = 50;
	localparam int LINES_DEF = 18;
	localparam logic [7:0] CODE_BELL = 8'h07;
	localparam logic [7:0] CODE_BS = 8'h08;
	localparam logic [7:0] CODE_LF = 8'h0a;
	localparam logic [7:0] CODE_FF = 8'h0c;
	localparam logic [7:0] CODE_CR = 8'h0d;
	localparam logic [7:0] CTRL_LIMIT = 8'h20;
	localparam logic [7:0] PRINT_LIMIT = 8'h80;
	localparam logic [4:0] ATTR_PATTERN = 5'h10;
	localparam int ATTR_UL_BIT = 2;
	localparam int ATTR_BL_BIT = 1;
	localparam int ATTR_INV_BIT = 0;
	localparam logic [2:0] ATTR_RESET = 3'h0;
	localparam logic [6:0] POS_RESET = 7'h01;
	typedef struct packed {
		logic underline;
		logic blink;
		logic inverse;
	} attr_s;
	typedef struct packed {
		logic [7:0] code;
		logic msgLine;
	} req_s;
	typedef struct packed {
		logic [7:0] glyph;
		attr_s attr;
		logic [6:0] col;
		logic [6:0] line;
		logic msgLine;
	} wr_s;
endpackage

// [rtl/key_sync.sv]
`timescale 1ns/10ps
module key_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic keyPin,
	output logic keyPress
);
	// ***************
	// two-flop sync, then edge
	// ***************
	logic s1_r, s2_r, s3_r;
	logic s1_nxt, s2_nxt, s3_nxt;
	always_comb begin
		s1_nxt = keyPin;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end
	// no debounce: key assumed clean
	assign keyPress = s2_r & ~s3_r;
endmodule

// [dv/host_stream.sv]
`timescale 1ns/10ps
// ****
// host byte stream
// ****
module host_stream import crt_char_pkg::*; (
	input wire logic clk,
	output logic inValid,
	output req_s inReq
);
	initial begin
		inValid = 1'b0;
		inReq = '0;
	end
	// idle lines flip so a stale byte never reads as fresh
	task automatic send(input logic [7:0] c, input logic m);
		@(posedge clk);
		inValid <= 1'b1;
		inReq <= '{code: c, msgLine: m};
		@(posedge clk);
		inValid <= 1'b0;
		inReq <= ~inReq;
	endtask
endmodule

// [dv/crt_char_interpreter_test.sv]
`timescale 1ns/10ps
module crt_char_interpreter_test import crt_char_pkg::*;;
	logic clk, rstn, inValid, modeKey, modeWrite, wrValid, scrollUp, beep, ctrlDisplay, sc;
	logic [7:0] modeData;
	logic [1:0] blankLines;
	logic [6:0] printCol, printLine;
	req_s inReq;
	wr_s wrOut, w, e;
	attr_s attrState, ea;
	wr_s expQ[$];
	int failures = 0, num_checks = 0, cyc = 0, ec, el;
	integer seed = 32'h5ceb;
	host_stream host (.clk(clk), .inValid(inValid), .inReq(inReq));
	crt_char_interpreter dut (.clk(clk), .rstn(rstn), .inValid(inValid), .inReq(inReq), .modeKey(modeKey),
		.modeWrite(modeWrite), .modeData(modeData), .wrValid(wrValid), .wrOut(wrOut), .scrollUp(scrollUp),
		.blankLines(blankLines), .beep(beep), .ctrlDisplay(ctrlDisplay), .attrState(attrState),
		.printCol(printCol), .printLine(printLine));
	// ****
	// compare and close
	// ****
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkWr(input wr_s got, input wr_s exp);
		chk(got[25:2], exp[25:2]);
		chk(got[1:0], exp[1:0]);
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic tx(input logic [7:0] b, input logic m = 1'b0);
		host.send(b, m);
		#1;
	endtask
	// expected position model; wrap and clamp happen on arrival
	task automatic glyph(input logic [7:0] b, input logic m = 1'b0);
		if (ec > COLS_DEF && !m) begin
			ec = 1;
			el++;
		end
		sc = el > LINES_DEF && !m;
		if (sc)
			el = LINES_DEF;
		expQ.push_back('{glyph: b, attr: ea, col: ec[6:0], line: el[6:0], msgLine: m});
		tx(b, m);
		if (m) begin
		end else if (b == CODE_CR) begin
			ec = 1;
			el++;
		end else
			ec++;
		chk({scrollUp, printLine, printCol}, {sc, el[6:0], ec[6:0]});
	endtask
	// ****
	// clock, monitor, timeout
	// ****
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (wrValid === 1'b1) begin
			e = (expQ.size() > 0) ? expQ.pop_front() : ~wrOut;
			w = wrOut;
			// message line position is not ours to predict
			if (e.msgLine)
				{w.col, w.line} = {e.col, e.line};
			chkWr(w, e);
		end
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	// ****
	// scenarios
	// ****
	initial begin
		rstn = 1'b0;
		modeKey = 1'b0;
		modeWrite = 1'b0;
		modeData = 8'h00;
		ea = '0;
		ec = 1;
		el = 1;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk({ctrlDisplay, attrState, printLine, printCol}, {1'b0, 3'h0, 7'h01, 7'h01});
		glyph(8'h41);
		for (int i = 0; i < 2; i++) begin
			tx(CODE_BS);
			chk(printCol, 7'h01);
		end
		ec = 1;
		for (int i = 0; i < 32; i++)
			if (!(i inside {7, 8, 10, 12, 13})) begin
				tx(8'(i));
				chk({beep, scrollUp, attrState, printLine, printCol}, {5'h00, 7'h01, 7'h01});
			end
		tx(CODE_BELL);
		chk({beep, printLine, printCol}, {1'b1, 7'h01, 7'h01});
		glyph(8'h42);
		tx(CODE_LF);
		el++;
		chk({printLine, printCol}, {el[6:0], ec[6:0]});
		tx(CODE_CR);
		ec = 1;
		chk({printLine, printCol}, {el[6:0], 7'h01});
		@(posedge clk);
		modeWrite <= 1'b1;
		modeData <= 8'($random(seed)) | 8'h01;
		@(posedge clk);
		modeWrite <= 1'b0;
		@(posedge clk);
		#1;
		chk(ctrlDisplay, 1'b1);
		glyph(CODE_BELL);
		chk(beep, 1'b0);
		glyph(CODE_CR);
		@(posedge clk);
		modeKey <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk(ctrlDisplay, 1'b0);
		modeKey <= 1'b0;
		for (int a = 128; a < 136; a++) begin
			tx(8'(a));
			ea = attr_s'(a[2:0]);
			chk(attrState, ea);
			glyph(8'h21 + 8'(a[2:0]));
			glyph(8'h61, 1'b1);
		end
		// mid-run reset with mode, attributes and position all away from reset values
		@(posedge clk);
		modeWrite <= 1'b1;
		@(posedge clk);
		modeWrite <= 1'b0;
		#1;
		chk(ctrlDisplay, 1'b1);
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		#1;
		chk({ctrlDisplay, attrState, printLine, printCol}, {1'b0, 3'h0, 7'h01, 7'h01});
		ea = '0;
		ec = 1;
		el = 1;
		tx(8'h80);
		ea = '0;
		chk(attrState, 3'h0);
		tx(CODE_FF);
		ec = 1;
		el = LINES_DEF;
		chk({scrollUp, blankLines, printLine, printCol}, {3'h6, 7'(LINES_DEF), 7'h01});
		repeat (COLS_DEF + 3)
			glyph(8'h20 + 8'($unsigned($random(seed)) % 96));
		repeat (3) @(posedge clk);
		chk(expQ.size(), 0);
		conclude();
	end
endmodule
